/* File: inc/pdp_pkg.sv */
// Constants, register map and types for the two-channel pulse-division PWM
package pdp_pkg;

  // Channel count and widths
  localparam int PDP_NCH = 2;
  localparam int PDP_AW = 16;
  localparam int PDP_DW = 8;
  localparam int PDP_DUTY_W = 10;

  // Register addresses, index 0 is channel 1
  localparam logic [15:0] PDP_SEL_ADDR [PDP_NCH] = '{16'hFFD0, 16'hFFCD};
  localparam logic [15:0] PDP_DUTYU_ADDR [PDP_NCH] = '{16'hFFD1, 16'hFFCE};
  localparam logic [15:0] PDP_DUTYL_ADDR [PDP_NCH] = '{16'hFFD2, 16'hFFCF};
  localparam logic [15:0] PDP_GATE_ADDR = 16'hFFFB;

  // Reset values and read answers
  localparam logic [7:0] PDP_SEL_RESET = 8'hFC;
  localparam logic [7:0] PDP_DUTYU_RESET = 8'hFC;
  localparam logic [7:0] PDP_DUTYL_RESET = 8'h00;
  localparam logic [7:0] PDP_GATE_RESET = 8'hFF;
  localparam logic [7:0] PDP_WO_READ = 8'hFF;
  localparam logic [7:0] PDP_UNMAPPED_READ = 8'h00;

  // Reserved bit masks, these bits always hold one
  localparam logic [7:0] PDP_SEL_RSVD = 8'hFC;
  localparam logic [7:0] PDP_DUTYU_RSVD = 8'hFC;
  localparam logic [7:0] PDP_GATE_RSVD = 8'hE0;

  // Clock-stop bit positions in the gate register
  localparam int PDP_STOP_BIT [PDP_NCH] = '{1, 4};

  // Waveform geometry in half input-clock units
  localparam int PDP_SUBS = 4;
  localparam int PDP_SUB_W = 2;
  localparam int PDP_SUB_CNT_W = 8;
  localparam logic [PDP_DUTY_W:0] PDP_DUTY_OFFSET = 11'h004;

  // Input clock selection codes
  typedef enum logic [1:0] {PDP_DIV1, PDP_DIV2, PDP_DIV4, PDP_DIV8} pdp_clk_sel_t;

  // Clocks per half input-clock unit for each code; code 0 is below one clock
  localparam logic [2:0] PDP_HALF_CLKS [4] = '{3'h1, 3'h1, 3'h2, 3'h4};

endpackage

/* File: rtl/pdp_prescale.sv */
// Prescaler giving one-cycle ticks per half input-clock unit, or one per clock for code 0
`timescale 1ns/1ps
module pdp_prescale (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic [1:0] clkSel,
  // Tick
  output logic tick
);
  import pdp_pkg::*;

  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  wire logic [2:0] limit = PDP_HALF_CLKS[clkSel];
  wire logic atLimit = (cnt_q + 3'h1) >= limit;

  // Tick on the last clock of each unit
  assign tick = run && atLimit;
  assign cnt_d = (!run || atLimit) ? 3'h0 : cnt_q + 3'h1;

  // Counter restarts when stopped so the phase is clean on release
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

/* File: rtl/pdp_split.sv */
// Splits the total high time into the width of one sub-period pulse
`timescale 1ns/1ps
module pdp_split (
  // Duty and sub-period index
  input wire logic [9:0] duty,
  input wire logic [1:0] subIdx,
  // Pulse width in half input-clock units
  output logic [8:0] width
);
  import pdp_pkg::*;

  wire logic [10:0] total = {1'b0, duty} + PDP_DUTY_OFFSET;
  wire logic [8:0] base = total[10:2];
  wire logic extra = subIdx < total[1:0];

  // Remainder goes to the earliest sub-periods
  assign width = base + {8'h00, extra};
endmodule

/* File: rtl/pdp_top.sv */
// Two-channel pulse-division PWM with register port
`timescale 1ns/1ps
module pdp_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [pdp_pkg::PDP_AW-1:0] regAddr,
  input wire logic [pdp_pkg::PDP_DW-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [pdp_pkg::PDP_DW-1:0] regRdData,
  // Chip power mode: high in watch, subactive, subsleep or standby
  input wire logic sysLowPower,
  // Waveform pins
  output logic ch1WaveOut,
  output logic ch2WaveOut
);
  import pdp_pkg::*;

  // Shared gate register and read path
  logic [7:0] gate_q;
  logic [7:0] rdData_q;
  logic [7:0] rdData_d;
  logic [PDP_NCH-1:0] hitWo;
  logic [PDP_NCH-1:0] waveOut_q;

  wire logic gateWr = regWrEn && (regAddr == PDP_GATE_ADDR);
  wire logic gateHit = regAddr == PDP_GATE_ADDR;

  // Reads of write-only registers answer all ones
  assign rdData_d = !regRdEn ? 8'h00 :
                    (|hitWo) ? PDP_WO_READ :
                    gateHit ? gate_q :
                    PDP_UNMAPPED_READ;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rdData_q <= 8'h00;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  // Gate register; reserved top bits stay one
  always_ff @(posedge clk) begin
    if (reset) begin
      gate_q <= PDP_GATE_RESET;
    end else if (gateWr) begin
      gate_q <= regWrData | PDP_GATE_RSVD;
    end
  end

  assign regRdData = rdData_q;
  assign ch1WaveOut = waveOut_q[0];
  assign ch2WaveOut = waveOut_q[1];

  // One identical generator per channel
  for (genvar ch = 0; ch < PDP_NCH; ch++) begin : g_ch
    logic [7:0] sel_q;
    logic [7:0] dutyU_q;
    logic [7:0] dutyL_q;
    logic [9:0] pend_q;
    logic [9:0] pend_d;
    logic pendValid_q;
    logic pendValid_d;
    logic [9:0] duty_q;
    logic [9:0] duty_d;
    logic [7:0] subCnt_q;
    logic [7:0] subCnt_d;
    logic [1:0] subIdx_q;
    logic [1:0] subIdx_d;
    logic wave_d;
    logic tick;
    logic [8:0] width;

    // Address decode
    wire logic selHit = regAddr == PDP_SEL_ADDR[ch];
    wire logic upHit = regAddr == PDP_DUTYU_ADDR[ch];
    wire logic loHit = regAddr == PDP_DUTYL_ADDR[ch];
    wire logic selWr = regWrEn && selHit;
    wire logic upWr = regWrEn && upHit;
    wire logic loWr = regWrEn && loHit;
    assign hitWo[ch] = selHit || upHit || loHit;

    // Standby bit or chip low-power mode halts the waveform only
    wire logic run = gate_q[PDP_STOP_BIT[ch]] && !sysLowPower;
    wire logic [1:0] clkSel = sel_q[1:0];

    // Code 0 has half-clock resolution, so two units pass per clock
    wire logic [8:0] step = (clkSel == PDP_DIV1) ? 9'h002 : 9'h001;
    wire logic [8:0] nextCnt = {1'b0, subCnt_q} + step;
    wire logic subWrap = nextCnt[8];
    wire logic periodEnd = tick && subWrap && (subIdx_q == 2'(PDP_SUBS - 1));

    // Software registers; contents survive every stopped mode
    always_ff @(posedge clk) begin
      if (reset) begin
        sel_q <= PDP_SEL_RESET;
        dutyU_q <= PDP_DUTYU_RESET;
        dutyL_q <= PDP_DUTYL_RESET;
      end else begin
        if (selWr) begin
          sel_q <= regWrData | PDP_SEL_RSVD;
        end
        if (upWr) begin
          dutyU_q <= regWrData | PDP_DUTYU_RSVD;
        end
        if (loWr) begin
          dutyL_q <= regWrData;
        end
      end
    end

    // Upper byte as it stands once this cycle's write lands
    wire logic [7:0] dutyU_d = upWr ? (regWrData | PDP_DUTYU_RSVD) : dutyU_q;

    // Upper write latches the full value; a new write beats the flag clear at the load
    assign pend_d = upWr ? {dutyU_d[1:0], dutyL_q} : pend_q;
    assign pendValid_d = upWr || (pendValid_q && !periodEnd);
    assign duty_d = (periodEnd && pendValid_q) ? pend_q : duty_q;

    // Sub-period counters in half input-clock units
    assign subCnt_d = !run ? 8'h00 : tick ? nextCnt[7:0] : subCnt_q;
    assign subIdx_d = !run ? 2'h0 : (tick && subWrap) ? subIdx_q + 2'h1 : subIdx_q;

    // Each pulse opens its sub-period; code 0 rounds half clocks up
    assign wave_d = run && ({1'b0, subCnt_q} < width);

    pdp_prescale u_prescale (
      .clk(clk),
      .reset(reset),
      .run(run),
      .clkSel(clkSel),
      .tick(tick)
    );

    pdp_split u_split (
      .duty(duty_q),
      .subIdx(subIdx_q),
      .width(width)
    );

    // Generator state
    always_ff @(posedge clk) begin
      if (reset) begin
        pend_q <= 10'h000;
        pendValid_q <= 1'b0;
        duty_q <= 10'h000;
        subCnt_q <= 8'h00;
        subIdx_q <= 2'h0;
        waveOut_q[ch] <= 1'b0;
      end else begin
        pend_q <= pend_d;
        pendValid_q <= pendValid_d;
        duty_q <= duty_d;
        subCnt_q <= subCnt_d;
        subIdx_q <= subIdx_d;
        waveOut_q[ch] <= wave_d;
      end
    end
  end
endmodule

/* File: tb/pdp_checker.sv */
// Port assertions for the two-channel pulse-division PWM
`timescale 1ns/1ps
module pdp_checker import pdp_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [PDP_AW-1:0] regAddr,
  input wire logic [PDP_DW-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [PDP_DW-1:0] regRdData,
  // Mode and pins
  input wire logic sysLowPower,
  input wire logic ch1WaveOut,
  input wire logic ch2WaveOut
);
  logic [7:0] gate_q;
  // Address decode; the six write-only bytes are contiguous
  wire woHit = regAddr inside {[16'hFFCD:16'hFFD2]};
  wire gateHit = regAddr == PDP_GATE_ADDR;
  // Shadow of the gate byte, so stop periods are known here
  always_ff @(posedge clk) begin
    if (reset) gate_q <= PDP_GATE_RESET;
    else if (regWrEn && gateHit) gate_q <= regWrData;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_rd_idle_zero: assert property (!$past(regRdEn) |-> regRdData == 8'h00)
    else $error("read data outside answer cycle");
  a_wo_read_ones: assert property ($past(regRdEn && woHit) |-> regRdData == PDP_WO_READ)
    else $error("write-only byte read not all ones");
  a_unmapped_zero: assert property ($past(regRdEn && !woHit && !gateHit) |-> !regRdData)
    else $error("unmapped read not zero");
  a_gate_read: assert property ($past(regRdEn && gateHit) |->
    regRdData == ($past(gate_q) | PDP_GATE_RSVD))
    else $error("gate byte read wrong");
  a_stop_ch1: assert property (!(gate_q[1] | $past(gate_q[1]) | $past(gate_q[1], 2)
    | $past(gate_q[1], 3)) |-> !ch1WaveOut)
    else $error("stopped channel 1 drives high");
  a_stop_ch2: assert property (!(gate_q[4] | $past(gate_q[4]) | $past(gate_q[4], 2)
    | $past(gate_q[4], 3)) |-> !ch2WaveOut)
    else $error("stopped channel 2 drives high");
  a_lowpwr_quiet: assert property (sysLowPower [*4] |-> !ch1WaveOut && !ch2WaveOut)
    else $error("waveform in low-power mode");
  a_reset_quiet: assert property ($past(reset) |-> !ch1WaveOut && !ch2WaveOut && !regRdData)
    else $error("outputs not quiet after reset");
  // Main scenarios reached
  c_gate_read: cover property (regRdEn && gateHit);
  c_ch1_stop: cover property (!gate_q[1] && !$past(gate_q[1], 3));
  c_ch2_stop: cover property (!gate_q[4] && !$past(gate_q[4], 3));
  c_wave_rise: cover property ($rose(ch1WaveOut));
endmodule
bind pdp_top pdp_checker pdp_checker_i (.clk(clk), .reset(reset), .regAddr(regAddr),
  .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
  .sysLowPower(sysLowPower), .ch1WaveOut(ch1WaveOut), .ch2WaveOut(ch2WaveOut));

/* File: tb/pdp_lpf.sv */
// Low-pass filter stand-in that integrates the high time of one pin
`timescale 1ns/1ps
module pdp_lpf (
  // Clock and control
  input wire logic clk,
  input wire logic clr,
  // Pin in, high clocks out
  input wire logic wave,
  output logic [12:0] acc
);
  // Charge counter; an unknown level adds nothing, so it cannot pass
  always_ff @(posedge clk) begin
    if (clr) acc <= 13'h0000;
    else if (wave === 1'b1) acc <= acc + 13'h0001;
  end
endmodule

/* File: tb/pulse_division_pwm_dac_bench.sv */
// Self-checking bench for the two-channel pulse-division PWM
`timescale 1ns/1ps
module pulse_division_pwm_dac_bench;
  import pdp_pkg::*;
  typedef struct packed {logic wr; logic [15:0] a; logic [7:0] d; logic [7:0] e;} pdp_row_t;
  localparam pdp_row_t ROWS [11] = '{
    '{1'b0, 16'hFFD0, 8'h00, 8'hFF}, '{1'b0, 16'hFFD1, 8'h00, 8'hFF},
    '{1'b0, 16'hFFD2, 8'h00, 8'hFF}, '{1'b0, 16'hFFCD, 8'h00, 8'hFF},
    '{1'b0, 16'hFFCE, 8'h00, 8'hFF}, '{1'b0, 16'hFFCF, 8'h00, 8'hFF},
    '{1'b0, 16'hFFFB, 8'h00, 8'hFF}, '{1'b0, 16'h0000, 8'h00, 8'h00},
    '{1'b1, 16'hFFFB, 8'h00, 8'h00}, '{1'b0, 16'hFFFB, 8'h00, 8'hE0},
    '{1'b1, 16'hFFFB, 8'hFF, 8'h00}};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0] regWrData = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic sysLowPower = 1'b0;
  logic clr = 1'b1;
  wire logic [7:0] regRdData;
  wire logic ch1WaveOut;
  wire logic ch2WaveOut;
  wire logic [12:0] acc1;
  wire logic [12:0] acc2;
  int n_mismatch = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  pdp_top pdp_top_i (.clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .sysLowPower(sysLowPower),
    .ch1WaveOut(ch1WaveOut), .ch2WaveOut(ch2WaveOut));
  pdp_lpf lpf1_i (.clk(clk), .clr(clr), .wave(ch1WaveOut), .acc(acc1));
  pdp_lpf lpf2_i (.clk(clk), .clr(clr), .wave(ch2WaveOut), .acc(acc2));
  // Compare read data, count, report
  task automatic chkRead(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Compare charge over one period, count, report
  task automatic chkCharge(input logic [12:0] got, input logic [12:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One strobe cycle; read data is settled when this returns
  task automatic busOp(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrEn <= wr;
    regRdEn <= !wr;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrEn <= 1'b0;
    regRdEn <= 1'b0;
    #1;
  endtask
  // Mode 2 loads select and full duty, 1 select and lower byte only, 0 nothing
  task automatic wave(input int ch, input logic [1:0] code, input logic [9:0] duty,
      input int mode, input logic [12:0] exp);
    int per;
    per = 512 << code;
    if (mode > 0) busOp(1'b1, PDP_SEL_ADDR[ch], {6'h3F, code});
    if (mode > 0) busOp(1'b1, PDP_DUTYL_ADDR[ch], duty[7:0]);
    if (mode == 2) busOp(1'b1, PDP_DUTYU_ADDR[ch], {6'h00, duty[9:8]});
    // Two periods let a pending duty land before integrating one period
    repeat (2 * per) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (per) @(posedge clk);
    #1;
    chkCharge(ch ? acc2 : acc1, exp);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 11; i++) begin
      busOp(ROWS[i].wr, ROWS[i].a, ROWS[i].d);
      if (!ROWS[i].wr) chkRead(regRdData, ROWS[i].e);
    end
    // Code 0 widths are rounded up to whole clocks
    wave(0, 2'h0, 10'h000, 0, 13'h0004);
    wave(1, 2'h0, 10'h004, 2, 13'h0004);
    wave(0, 2'h3, 10'h000, 2, 13'h0010);
    wave(1, 2'h1, 10'h155, 2, 13'h0159);
    wave(1, 2'h1, 10'h000, 1, 13'h0159);
    wave(0, 2'h2, 10'h3FB, 2, 13'h07FE);
    wave(1, 2'h1, 10'h000, 0, 13'h0159);
    busOp(1'b1, PDP_GATE_ADDR, 8'hFD);
    wave(0, 2'h2, 10'h000, 0, 13'h0000);
    // Channel 2 stopped alone; channel 1 must run on untouched
    busOp(1'b1, PDP_GATE_ADDR, 8'hEF);
    wave(1, 2'h1, 10'h000, 0, 13'h0000);
    wave(0, 2'h2, 10'h000, 0, 13'h07FE);
    busOp(1'b1, PDP_GATE_ADDR, 8'hFF);
    @(posedge clk) sysLowPower <= 1'b1;
    wave(1, 2'h1, 10'h000, 0, 13'h0000);
    @(posedge clk) sysLowPower <= 1'b0;
    wave(1, 2'h1, 10'h000, 0, 13'h0159);
    wave(0, 2'h2, 10'h000, 0, 13'h07FE);
    // Mid-run reset returns both channels to code 0 and duty 0
    @(posedge clk) reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    wave(0, 2'h0, 10'h000, 0, 13'h0004);
    wave(1, 2'h0, 10'h000, 0, 13'h0004);
    summarize();
  end
endmodule
